/* src/load_monitor_alarm_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "load_monitor_consts.vh"

module load_monitor_alarm_unit
#(
   parameter PW          = 10,
   parameter DW          = 14,
   parameter TICK_CYC    = `TICK_CYCLES,
   parameter FLASH_CYC   = `FLASH_HALF_CYC,
   parameter LOG_DEPTH   = 9
)
(
   // Clock and reset
   input  wire          clk,
   input  wire          rstn,
   // AHB-Lite slave
   input  wire          hsel,
   input  wire [7:0]    haddr,
   input  wire [1:0]    htrans,
   input  wire          hwrite,
   input  wire [2:0]    hsize,
   input  wire [31:0]   hwdata,
   input  wire          hready,
   output wire          hreadyout,
   output wire          hresp,
   output reg  [31:0]   hrdata,
   // Power stage
   input  wire [PW-1:0] shaft_power,
   input  wire          motor_running,
   input  wire          stop_ramp,
   input  wire          jogging,
   input  wire          braking,
   input  wire          motor_standstill,
   input  wire          start_cmd,
   output reg           run_allow,
   output wire          coast_cmd,
   output wire          soft_stop_cmd,
   // Operator side
   input  wire          autoset_pin,
   input  wire          trip_reset,
   input  wire [31:0]   rtc_time,
   output reg           trip_led,
   output reg           warning_relay,
   output reg           trip_relay,
   output reg  [3:0]    alarm_status,
   output reg           tripped_status_tag,
   output reg           soft_trip_marker,
   output reg  [2:0]    warning_msg,
   output reg  [2:0]    trip_cause
);

   // Register file.
   reg  [15:0]   start_delay;
   reg  [31:0]   level_reg [0:3];
   reg  [PW-1:0] margin [0:3];
   reg  [PW-1:0] normal_load;
   reg           autoset_mode;
   // Trip log: cause, timestamp and snapshot per entry.
   reg  [2:0]    log_cause [0:LOG_DEPTH-1];
   reg  [31:0]   log_time  [0:LOG_DEPTH-1];
   reg  [15:0]   log_snap  [0:LOG_DEPTH-1];
   // Trip state.
   reg           tripped;
   reg           hard;
   reg           soft_done;
   // Timers.
   reg  [15:0]   tick_cnt;
   reg           tick;
   reg  [15:0]   start_cnt;
   reg           start_done;
   reg           was_running;
   reg  [22:0]   flash_cnt;
   reg           flash;
   // Bus data phase.
   reg           wr_pend;
   reg  [7:0]    wr_addr;
   // Autoset edge.
   wire          autoset_lvl;
   reg           autoset_d;

   wire          bus_go;
   wire          autoset_sw;
   wire          autoset_req;
   wire          sup_active;
   wire [3:0]    fire;
   reg           any_warn;
   reg           any_soft;
   reg           any_hard;
   reg  [2:0]    first_trip;
   reg  [2:0]    next_warn_msg;
   reg  [31:0]   rd_mux;
   integer       i;
   integer       sev_i;
   integer       log_i;
   integer       ind_i;
   integer       rd_i;
   genvar        g;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign bus_go    = hsel && htrans[1] && hready;

   pin_sync u_autoset_sync
   (
      .clk   (clk),
      .rstn  (rstn),
      .pin   (autoset_pin),
      .level (autoset_lvl)
   );

   assign autoset_sw  = wr_pend && (wr_addr == `REG_CTRL) && hwdata[`CTRL_AUTOSET];
   assign autoset_req = (autoset_lvl && !autoset_d) || autoset_sw;

   // Index 0 overload, 1 overload pre, 2 underload pre, 3 underload.
   assign sup_active = motor_running && start_done && !stop_ramp && !jogging && !braking;

   generate
      for (g = 0; g < 4; g = g + 1)
      begin : chan
         load_alarm_channel #(.PW(PW), .DW(DW)) u_chan
         (
            .clk     (clk),
            .rstn    (rstn),
            .tick    (tick),
            .enable  (sup_active),
            .is_over (g < 2),
            .power   (shaft_power),
            .level   (level_reg[g][PW-1:0]),
            .delay   (level_reg[g][`LVL_DLY_HI:`LVL_DLY_LO]),
            .fire    (fire[g])
         );
      end
   endgenerate

   function [PW-1:0] add_sat;
      input [PW-1:0] a;
      input [PW-1:0] b;
      reg   [PW:0]   s;
      begin
         s = {1'b0, a} + {1'b0, b};
         add_sat = s[PW] ? {PW{1'b1}} : s[PW-1:0];
      end
   endfunction

   function [PW-1:0] sub_sat;
      input [PW-1:0] a;
      input [PW-1:0] b;
      begin
         sub_sat = (a > b) ? (a - b) : {PW{1'b0}};
      end
   endfunction

   // Severity of the currently qualified alarms.
   always @*
   begin
      any_warn      = 1'b0;
      any_soft      = 1'b0;
      any_hard      = 1'b0;
      first_trip    = `MSG_NONE;
      next_warn_msg = `MSG_NONE;
      // Each combinational loop owns its index, so no process wakes another at the same time.
      for (sev_i = 3; sev_i >= 0; sev_i = sev_i - 1)
      begin
         if (fire[sev_i])
         begin
            case (level_reg[sev_i][`LVL_ACT_HI:`LVL_ACT_LO])
               `ACT_WARN:
               begin
                  any_warn      = 1'b1;
                  next_warn_msg = sev_i[2:0] + 3'h1;
               end
               `ACT_SOFT:
               begin
                  any_soft   = 1'b1;
                  first_trip = (first_trip == `MSG_NONE || !any_hard) ? sev_i[2:0] + 3'h1
                                                                     : first_trip;
               end
               `ACT_HARD:
               begin
                  any_hard   = 1'b1;
                  first_trip = sev_i[2:0] + 3'h1;
               end
               default:
               begin
                  any_warn = any_warn;
               end
            endcase
         end
      end
   end

   // Millisecond tick, start delay and 2 Hz flash base.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         tick_cnt    <= 16'h0000;
         tick        <= 1'b0;
         start_cnt   <= 16'h0000;
         start_done  <= 1'b0;
         was_running <= 1'b0;
         flash_cnt   <= 23'h000000;
         flash       <= 1'b0;
         autoset_d   <= 1'b0;
      end
      else
      begin
         autoset_d   <= autoset_lvl;
         was_running <= motor_running;
         tick        <= (tick_cnt == TICK_CYC[15:0] - 16'h0001);
         tick_cnt    <= (tick_cnt == TICK_CYC[15:0] - 16'h0001) ? 16'h0000
                                                                 : tick_cnt + 16'h0001;
         if (!motor_running || !was_running)
         begin
            start_cnt  <= 16'h0000;
            start_done <= 1'b0;
         end
         else if (start_cnt >= start_delay)
            start_done <= 1'b1;
         else if (tick)
            start_cnt <= start_cnt + 16'h0001;
         if (flash_cnt == FLASH_CYC[22:0] - 23'h000001)
         begin
            flash_cnt <= 23'h000000;
            flash     <= ~flash;
         end
         else
            flash_cnt <= flash_cnt + 23'h000001;
      end
   end

   // Trip latch, restart permission and log.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         tripped    <= 1'b0;
         hard       <= 1'b0;
         soft_done  <= 1'b0;
         run_allow  <= 1'b0;
         trip_cause <= `MSG_NONE;
         for (log_i = 0; log_i < LOG_DEPTH; log_i = log_i + 1)
         begin
            log_cause[log_i] <= `MSG_NONE;
            log_time[log_i]  <= 32'h0000_0000;
            log_snap[log_i]  <= 16'h0000;
         end
      end
      else if (!tripped && (any_hard || any_soft))
      begin
         tripped    <= 1'b1;
         hard       <= any_hard;
         soft_done  <= 1'b0;
         run_allow  <= 1'b0;
         trip_cause <= first_trip;
         for (log_i = LOG_DEPTH - 1; log_i > 0; log_i = log_i - 1)
         begin
            log_cause[log_i] <= log_cause[log_i-1];
            log_time[log_i]  <= log_time[log_i-1];
            log_snap[log_i]  <= log_snap[log_i-1];
         end
         log_cause[0] <= first_trip;
         log_time[0]  <= rtc_time;
         log_snap[0]  <= {stop_ramp, jogging, braking, motor_running, 2'b00,
                          shaft_power[PW-1:0]};
      end
      else
      begin
         if (tripped && !hard && motor_standstill)
            soft_done <= 1'b1;
         if (tripped && trip_reset)
         begin
            tripped    <= 1'b0;
            hard       <= 1'b0;
            soft_done  <= 1'b0;
            trip_cause <= `MSG_NONE;
         end
         else if (!tripped && start_cmd)
            run_allow <= 1'b1;
      end
   end

   assign coast_cmd     = tripped && hard;
   assign soft_stop_cmd = tripped && !hard && !soft_done;

   // Indicators, relays and message.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         trip_led           <= 1'b0;
         warning_relay      <= 1'b0;
         trip_relay         <= 1'b0;
         alarm_status       <= 4'h0;
         tripped_status_tag <= 1'b0;
         soft_trip_marker   <= 1'b0;
         warning_msg        <= `MSG_NONE;
      end
      else
      begin
         if (tripped && (hard || soft_done))
            trip_led <= 1'b1;
         else
            trip_led <= flash && ((tripped && !hard) || any_warn);
         warning_relay      <= (tripped && !hard && !soft_done) || any_warn;
         trip_relay         <= tripped && (hard || soft_done);
         tripped_status_tag <= tripped && (hard || soft_done);
         soft_trip_marker   <= tripped && !hard && !soft_done;
         warning_msg        <= next_warn_msg;
         for (ind_i = 0; ind_i < 4; ind_i = ind_i + 1)
            alarm_status[ind_i] <= fire[ind_i] &&
               (level_reg[ind_i][`LVL_ACT_HI:`LVL_ACT_LO] != `ACT_NONE);
      end
   end

   // Register writes, manual thresholds and autoset.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         wr_pend      <= 1'b0;
         wr_addr      <= 8'h00;
         start_delay  <= `START_DLY_RST;
         normal_load  <= {PW{1'b0}};
         autoset_mode <= 1'b0;
         for (i = 0; i < 4; i = i + 1)
         begin
            level_reg[i] <= `LEVEL_RST;
            margin[i]    <= `MARGIN_RST;
         end
      end
      else
      begin
         wr_pend <= bus_go && hwrite;
         wr_addr <= haddr;
         if (wr_pend && wr_addr == `REG_START_DLY)
            start_delay <= hwdata[15:0];
         for (i = 0; i < 4; i = i + 1)
         begin
            if (wr_pend && wr_addr == `REG_MARGIN0 + 8'h04 * i[7:0])
               margin[i] <= hwdata[PW-1:0];
            if (wr_pend && wr_addr == `REG_LEVEL0 + 8'h04 * i[7:0])
            begin
               level_reg[i] <= {hwdata[31:16], {(16-PW){1'b0}}, hwdata[PW-1:0]};
               autoset_mode <= 1'b0;
               normal_load  <= {PW{1'b0}};
            end
         end
         if (autoset_req)
         begin
            autoset_mode <= 1'b1;
            normal_load  <= shaft_power;
            level_reg[0][PW-1:0] <= add_sat(shaft_power, margin[0]);
            level_reg[1][PW-1:0] <= add_sat(shaft_power, margin[1]);
            level_reg[2][PW-1:0] <= sub_sat(shaft_power, margin[2]);
            level_reg[3][PW-1:0] <= sub_sat(shaft_power, margin[3]);
         end
      end
   end

   // Read mux is sampled in the address phase, so data stands in the data phase.
   always @*
   begin
      rd_mux = 32'h0000_0000;
      if (haddr == `REG_START_DLY)
         rd_mux = {16'h0000, start_delay};
      else if (haddr == `REG_STATUS)
      begin
         rd_mux[PW-1:0]                       = normal_load;
         rd_mux[`ST_AUTO_MODE]                = autoset_mode;
         rd_mux[`ST_ACTIVE]                   = sup_active;
         rd_mux[`ST_FIRE_HI:`ST_FIRE_LO]      = fire;
         rd_mux[`ST_WARN_HI:`ST_WARN_LO]      = warning_msg;
      end
      else if (haddr == `REG_TRIP)
         rd_mux = {24'h000000, run_allow, soft_done, hard, tripped, 1'b0, trip_cause};
      for (rd_i = 0; rd_i < 4; rd_i = rd_i + 1)
      begin
         if (haddr == `REG_LEVEL0 + 8'h04 * rd_i[7:0])
            rd_mux = level_reg[rd_i];
         if (haddr == `REG_MARGIN0 + 8'h04 * rd_i[7:0])
            rd_mux = {{(32-PW){1'b0}}, margin[rd_i]};
      end
      for (rd_i = 0; rd_i < LOG_DEPTH; rd_i = rd_i + 1)
      begin
         if (haddr == `REG_LOG0 + 8'h08 * rd_i[7:0])
            rd_mux = {log_snap[rd_i], 13'h0000, log_cause[rd_i]};
         if (haddr == `REG_LOG0 + 8'h08 * rd_i[7:0] + 8'h04)
            rd_mux = log_time[rd_i];
      end
   end

   always @(posedge clk)
   begin
      if (!rstn)
         hrdata <= 32'h0000_0000;
      else if (bus_go && !hwrite)
         hrdata <= rd_mux;
   end

endmodule // load_monitor_alarm_unit

`default_nettype wire

/* src/load_monitor_consts.vh */
`ifndef LOAD_MONITOR_CONSTS_VH
`define LOAD_MONITOR_CONSTS_VH

// Register byte offsets.
`define REG_CTRL        8'h00
`define REG_START_DLY   8'h04
`define REG_LEVEL0      8'h10
`define REG_MARGIN0     8'h20
`define REG_STATUS      8'h30
`define REG_TRIP        8'h34
`define REG_LOG0        8'h40
`define LOG_LAST_OFS    8'h84

// Field positions.
`define CTRL_AUTOSET    0
`define LVL_ACT_LO      16
`define LVL_ACT_HI      17
`define LVL_DLY_LO      18
`define LVL_DLY_HI      31
`define ST_AUTO_MODE    16
`define ST_ACTIVE       17
`define ST_FIRE_LO      20
`define ST_FIRE_HI      23
`define ST_WARN_LO      24
`define ST_WARN_HI      26

// Alarm actions.
`define ACT_NONE        2'h0
`define ACT_WARN        2'h1
`define ACT_SOFT        2'h2
`define ACT_HARD        2'h3

// Warning message codes and trip causes (alarm index + 1).
`define MSG_NONE        3'h0
`define MSG_OVER_AL     3'h1
`define MSG_OVER_PRE    3'h2
`define MSG_UNDER_PRE   3'h3
`define MSG_UNDER_AL    3'h4

// Timing: clock rate, millisecond tick, 2 Hz flash half period.
`define CLK_HZ          20000000
`define TICK_MS         1
`define FLASH_HZ        2
`define TICK_CYCLES     (`CLK_HZ / 1000 * `TICK_MS)
`define FLASH_HALF_CYC  (`CLK_HZ / (2 * `FLASH_HZ))

// Reset values.
`define START_DLY_RST   16'h0000
`define LEVEL_RST       32'h0000_0000
`define MARGIN_RST      10'h000

`endif

/* src/pin_sync.v */
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; output only follows once stages two and three agree.
module pin_sync
(
   // Clock and reset
   input  wire clk,
   input  wire rstn,
   // Pin and synchronised level
   input  wire pin,
   output reg  level
);

   reg s1;
   reg s2;
   reg s3;

   always @(posedge clk)
   begin
      if (!rstn)
      begin
         s1    <= 1'b0;
         s2    <= 1'b0;
         s3    <= 1'b0;
         level <= 1'b0;
      end
      else
      begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            level <= s3;
      end
   end

endmodule // pin_sync

`default_nettype wire

/* src/load_alarm_channel.v */
`timescale 1ns/1ps
`default_nettype none

// One threshold comparison with its own qualifying delay in millisecond ticks.
module load_alarm_channel
#(
   parameter PW = 10,
   parameter DW = 14
)
(
   // Clock and reset
   input  wire          clk,
   input  wire          rstn,
   // Supervision inputs
   input  wire          tick,
   input  wire          enable,
   input  wire          is_over,
   input  wire [PW-1:0] power,
   input  wire [PW-1:0] level,
   input  wire [DW-1:0] delay,
   // Qualified alarm
   output wire          fire
);

   reg  [DW-1:0] cnt;
   wire          violated;

   assign violated = enable && (is_over ? (power > level) : (power < level));
   assign fire     = violated && (cnt >= delay);

   always @(posedge clk)
   begin
      if (!rstn)
         cnt <= {DW{1'b0}};
      else if (!violated)
         cnt <= {DW{1'b0}};
      else if (tick && (cnt != {DW{1'b1}}))
         cnt <= cnt + {{(DW-1){1'b0}}, 1'b1};
   end

endmodule // load_alarm_channel

`default_nettype wire

/* testbench/load_monitor_checker_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module load_monitor_checker
#(
   parameter FLASH_CYC = 8
)
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // Power stage side
   input wire logic       run_allow,
   input wire logic       coast_cmd,
   input wire logic       soft_stop_cmd,
   input wire logic       start_cmd,
   input wire logic       stop_ramp,
   input wire logic       jogging,
   input wire logic       braking,
   input wire logic       motor_standstill,
   // Operator side
   input wire logic       trip_reset,
   input wire logic       trip_led,
   input wire logic       warning_relay,
   input wire logic       trip_relay,
   input wire logic       tripped_status_tag,
   input wire logic       soft_trip_marker,
   input wire logic [3:0] alarm_status,
   input wire logic [2:0] warning_msg
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   logic        led_q;
   logic [31:0] run_len;

   // A stuck lamp would look steady, so bound each unchanged stretch while it should flash.
   always @(posedge clk)
   begin
      led_q   <= trip_led;
      run_len <= (warning_relay && !tripped_status_tag && trip_led == led_q) ? run_len + 1 : 32'h0;
   end

   sequence s_hard_on;
      $rose(coast_cmd);
   endsequence
   sequence s_trip_shown;
      trip_led && trip_relay && tripped_status_tag;
   endsequence
   sequence s_inhibit;
      (stop_ramp || jogging || braking) [*2];
   endsequence

   a_hard_shown: assert property (s_hard_on |=> s_trip_shown)
      else $error("hard trip not shown");
   a_trip_stops: assert property ((coast_cmd || soft_stop_cmd) |-> !run_allow)
      else $error("run allowed while tripped");
   a_start_refused: assert property (tripped_status_tag && !start_cmd |=> !run_allow)
      else $error("run allowed without start");
   a_reset_clears: assert property (trip_reset |-> ##2 !(tripped_status_tag || trip_relay))
      else $error("trip indication kept after reset");
   a_soft_stopping: assert property (soft_stop_cmd [*2] |-> warning_relay && soft_trip_marker)
      else $error("soft stop not indicated");
   a_soft_landed: assert property ($fell(soft_stop_cmd) && motor_standstill && !$past(trip_reset)
      |-> ##2 s_trip_shown)
      else $error("soft trip at rest not shown");
   a_inhibit_quiet: assert property (s_inhibit |=> alarm_status == 4'h0)
      else $error("alarm while inhibited");
   a_warn_msg_tied: assert property (warning_msg == 3'h2 |-> alarm_status[1])
      else $error("pre-alarm message without alarm");
   a_flash_rate: assert property (run_len <= FLASH_CYC)
      else $error("lamp not flashing");
endmodule // load_monitor_checker

bind load_monitor_alarm_unit load_monitor_checker #(.FLASH_CYC(FLASH_CYC)) u_checker
(
   .clk, .rstn, .run_allow, .coast_cmd, .soft_stop_cmd, .start_cmd, .stop_ramp, .jogging,
   .braking, .motor_standstill, .trip_reset, .trip_led, .warning_relay, .trip_relay,
   .tripped_status_tag, .soft_trip_marker, .alarm_status, .warning_msg
);
`default_nettype wire

/* testbench/motor_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_stage
#(
   parameter             PW   = 10,
   parameter logic [7:0] RAMP = 8'h10
)
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rstn,
   // Commands
   input  wire logic          run_allow,
   input  wire logic          coast_cmd,
   input  wire logic          soft_stop_cmd,
   input  wire logic [PW-1:0] load,
   // Run state
   output var  logic          motor_running,
   output var  logic          stop_ramp,
   output wire logic          motor_standstill,
   output wire logic [PW-1:0] shaft_power
);
   logic [7:0] ramp_left;

   // There is no estimate at rest, so the power reads zero then.
   assign shaft_power      = motor_running ? load : {PW{1'b0}};
   assign motor_standstill = !motor_running && !stop_ramp;

   always @(posedge clk)
   begin
      if (!rstn)
      begin
         motor_running <= 1'b0;
         stop_ramp     <= 1'b0;
         ramp_left     <= 8'h00;
      end
      else if (soft_stop_cmd && motor_running)
      begin
         motor_running <= 1'b0;
         stop_ramp     <= 1'b1;
         ramp_left     <= RAMP;
      end
      else if (stop_ramp)
      begin
         ramp_left <= ramp_left - 8'h01;
         stop_ramp <= (ramp_left != 8'h01);
      end
      else
         motor_running <= run_allow && !coast_cmd;
   end
endmodule // motor_stage
`default_nettype wire

/* testbench/load_monitor_alarm_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module load_monitor_alarm_unit_tb;
   localparam int FLASH = 8;

   logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0, seen;
   logic [31:0] hwdata = 32'h0000_0000, hrdata, q, rtc_time = 32'h0000_1234;
   logic        start_cmd = 1'b0, jogging = 1'b0, braking = 1'b0;
   logic        autoset_pin = 1'b0, trip_reset = 1'b0, motor_running, stop_ramp;
   logic        motor_standstill, run_allow, coast_cmd, soft_stop_cmd, trip_led;
   logic        warning_relay, trip_relay, tripped_status_tag, soft_trip_marker;
   logic [9:0]  load = 10'h064, shaft_power;
   logic [3:0]  alarm_status;
   logic [2:0]  warning_msg, trip_cause;
   int          failures = 0, checks = 0, n;

   load_monitor_alarm_unit #(.TICK_CYC(20), .FLASH_CYC(FLASH)) DUT
   (
      .clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .shaft_power, .motor_running,
      .stop_ramp, .jogging, .braking, .motor_standstill, .start_cmd, .run_allow,
      .coast_cmd, .soft_stop_cmd, .autoset_pin, .trip_reset, .rtc_time, .trip_led,
      .warning_relay, .trip_relay, .alarm_status, .tripped_status_tag,
      .soft_trip_marker, .warning_msg, .trip_cause
   );

   motor_stage u_motor
   (
      .clk, .rstn, .run_allow, .coast_cmd, .soft_stop_cmd, .load, .motor_running,
      .stop_ramp, .motor_standstill, .shaft_power
   );

   always #25 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= a;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      q = hrdata;
   endtask

   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q & m, e);
      chk(hresp, 1'b0);
   endtask

   task automatic go;
      @(posedge clk) start_cmd <= 1'b1;
      @(posedge clk) start_cmd <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic clear_trip;
      @(posedge clk) trip_reset <= 1'b1;
      @(posedge clk) trip_reset <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic t_regs;
      rdm(8'h10, 32'hffff_ffff, 32'h0000_0000);
      rdm(8'h40, 32'hffff_ffff, 32'h0000_0000);
      bus(1'b1, 8'h04, 32'h0000_0002);
      bus(1'b1, 8'h10, 32'h0003_0096);
      bus(1'b1, 8'h14, 32'h000d_0078);
      bus(1'b1, 8'h1c, 32'h0002_0032);
      rdm(8'h14, 32'hffff_ffff, 32'h000d_0078);
      rdm(8'h1c, 32'hffff_ffff, 32'h0002_0032);
      rdm(8'hfc, 32'hffff_ffff, 32'h0000_0000);
   endtask

   task automatic t_hard;
      @(posedge clk) load <= 10'h097;
      go();
      for (n = 0; n < 200 && coast_cmd !== 1'b1; n++) @(posedge clk);
      chk(n >= 15 && n < 60, 1);
      repeat (2) @(posedge clk);
      chk({trip_led, trip_relay, tripped_status_tag, run_allow, trip_cause}, 7'h71);
      rdm(8'h40, 32'hffff_0007, 32'h1097_0001);
      rdm(8'h44, 32'hffff_ffff, 32'h0000_1234);
      go();
      chk(run_allow, 1'b0);
      clear_trip();
      chk({trip_led, tripped_status_tag, coast_cmd, run_allow}, 4'h0);
      rdm(8'h40, 32'h0000_0007, 32'h0000_0001);
      @(posedge clk) load <= 10'h064;
      go();
      chk(run_allow, 1'b1);
   endtask

   task automatic t_warn;
      repeat (60) @(posedge clk);
      @(posedge clk) load <= 10'h079;
      repeat (30) @(posedge clk);
      @(posedge clk) load <= 10'h064;
      repeat (10) @(posedge clk);
      chk(alarm_status, 4'h0);
      @(posedge clk) load <= 10'h079;
      repeat (35) @(posedge clk);
      chk(warning_msg, 3'h0);
      for (n = 0; n < 100 && warning_msg !== 3'h2; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk(warning_msg, 3'h2);
      chk(alarm_status, 4'h2);
      chk({run_allow, warning_relay}, 2'h3);
      seen = 2'h0;
      repeat (2 * FLASH + 2) @(posedge clk) seen = seen | (trip_led ? 2'h2 : 2'h1);
      chk(seen, 2'h3);
      @(posedge clk) load <= 10'h078;
      repeat (5) @(posedge clk);
      chk({warning_msg, warning_relay, alarm_status}, 8'h00);
   endtask

   task automatic t_soft;
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk);
         jogging <= (i == 0);
         braking <= (i == 1);
         load    <= 10'h031;
         repeat (10) @(posedge clk);
         chk({alarm_status, soft_stop_cmd}, 5'h00);
         @(posedge clk);
         jogging <= 1'b0;
         braking <= 1'b0;
         load    <= 10'h064;
      end
      @(posedge clk) load <= 10'h031;
      for (n = 0; n < 50 && soft_stop_cmd !== 1'b1; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk({soft_trip_marker, warning_relay, trip_relay, trip_cause}, 6'h34);
      for (n = 0; n < 100 && motor_standstill !== 1'b1; n++) @(posedge clk);
      repeat (3) @(posedge clk);
      seen = 2'h0;
      repeat (2 * FLASH + 2) @(posedge clk) seen = seen | (trip_led ? 2'h2 : 2'h1);
      chk({seen, tripped_status_tag, trip_relay}, 4'hb);
      rdm(8'h40, 32'h0000_0007, 32'h0000_0004);
      rdm(8'h48, 32'h0000_0007, 32'h0000_0001);
      clear_trip();
      @(posedge clk) load <= 10'h03c;
      go();
   endtask

   task automatic t_auto;
      bus(1'b1, 8'h20, 32'h0000_000a);
      bus(1'b1, 8'h24, 32'h0000_0005);
      bus(1'b1, 8'h28, 32'h0000_0005);
      bus(1'b1, 8'h2c, 32'h0000_0014);
      @(posedge clk) autoset_pin <= 1'b1;
      repeat (6) @(posedge clk);
      autoset_pin <= 1'b0;
      repeat (6) @(posedge clk);
      rdm(8'h30, 32'h0001_03ff, 32'h0001_003c);
      rdm(8'h10, 32'h0000_03ff, 32'h0000_0046);
      rdm(8'h14, 32'h0000_03ff, 32'h0000_0041);
      rdm(8'h18, 32'h0000_03ff, 32'h0000_0037);
      rdm(8'h1c, 32'h0000_03ff, 32'h0000_0028);
      @(posedge clk) load <= 10'h03e;
      bus(1'b1, 8'h00, 32'h0000_0001);
      rdm(8'h10, 32'h0000_03ff, 32'h0000_0048);
      rdm(8'h1c, 32'h0000_03ff, 32'h0000_002a);
      bus(1'b1, 8'h18, 32'h0000_0020);
      rdm(8'h30, 32'h0001_03ff, 32'h0000_0000);
      rdm(8'h14, 32'h0000_03ff, 32'h0000_0043);
   endtask

   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      $display("t_regs ended");
      t_hard();
      $display("t_hard ended");
      t_warn();
      $display("t_warn ended");
      t_soft();
      $display("t_soft ended");
      t_auto();
      $display("t_auto ended");
      report_and_stop();
   end

   // The sequence needs about five hundred cycles; twenty thousand means a hang.
   initial
   begin
      #(50 * 20000);
      failures++;
      report_and_stop();
   end
endmodule // load_monitor_alarm_unit_tb
`default_nettype wire
